// file: pkg/sfcfe_pkg.sv
/*
 * sfcfe_pkg: shared constants of the serial flash control front end:
 * status bit positions, power-up value, opcodes, frame lengths, array geometry.
 * Assumes both the system-clock core and the serial-clock link include it.
 */
package sfcfe_pkg;

    // status register bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 4;
    localparam int ST_RSVD = 5;
    localparam int ST_AUTO = 6;
    localparam int ST_LOCK = 7;

    // power-up values: every block protected, all else clear
    localparam logic [2:0] PROTECT_LEVEL_RESET = 3'h7;
    localparam logic [7:0] STATUS_RESET = 8'h1C;

    // opcodes served by this front end
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] OPC_BYTE_PROGRAM = 8'h02;
    localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OPC_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OPC_AUTO_INCR = 8'hAD;

    // whole bus cycles (opcode included) each instruction must carry
    localparam logic [2:0] LEN_SHORT = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_ERASE = 3'h4;
    localparam logic [2:0] LEN_PROGRAM = 3'h5;
    localparam logic [2:0] LEN_AUTO_FIRST = 3'h6;
    localparam logic [2:0] LEN_AUTO_NEXT = 3'h3;
    localparam logic [2:0] LEN_MAX = 3'h7;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // array geometry: 16 blocks of 64 KB
    localparam int ADDR_W = 20;
    localparam int BLK_LSB = 16;
    localparam logic [4:0] BLOCK_COUNT = 5'h10;
    localparam logic [2:0] LEVEL_ALL = 3'h5;
    localparam logic [19:0] TOP_ADDR = 20'hFFFFF;
    localparam logic [19:0] WORD_STEP = 20'h00002;

    // core sequencing
    typedef enum logic {ST_IDLE, ST_WORK} sfcfe_state_t;

endpackage : sfcfe_pkg

// file: core/sfcfe_link.sv
/*
 * sfcfe_link: serial-clock side of the front end. Shifts opcode and argument
 * bytes in on rising sck, returns the status byte on falling sck.
 * Assumes si and hold_n are launched by the host on sck; status_word is a slow
 * level from the system-clock core; frame outputs are read only after cs_n rises.
 */
`timescale 1ns/100ps
module sfcfe_link (
    // serial pins
    input wire logic sck,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    // status to return
    input wire logic [7:0] status_word,
    // captured frame
    output logic [7:0] opcode,
    output logic [7:0] arg1,
    output logic [7:0] arg2,
    output logic [7:0] arg3,
    output logic [2:0] nbytes,
    output logic aligned,
    output logic frame_tog,
    // serial out
    output logic so,
    output logic so_oe_n
);
    typedef struct packed {
        logic [6:0] shift;
        logic [2:0] bit_cnt;
        logic [2:0] nbytes;
        logic [7:0] opcode;
        logic [7:0] arg1;
        logic [7:0] arg2;
        logic [7:0] arg3;
        logic aligned;
        logic frame_tog;
        logic [7:0] stat_meta;
        logic [7:0] stat_sync;
    } sfcfe_link_t;

    sfcfe_link_t q;
    sfcfe_link_t next_q;
    logic fresh;
    logic [2:0] cnt;
    logic [2:0] nb;
    logic [7:0] byte_in;
    logic reading;

    // frame start: cs_n high arms it, so counters restart with the next frame
    always_ff @(posedge sck or posedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            fresh <= 1'b1;
        end else if (cs_n) begin
            fresh <= 1'b1;
        end else if (hold_n) begin
            fresh <= 1'b0;
        end
    end

    // shifter; a low pause input freezes every field but the status sync stages, so the frame resumes intact
    always_comb begin
        next_q = q;
        next_q.stat_meta = status_word;
        next_q.stat_sync = q.stat_meta;
        cnt = fresh ? 3'h0 : q.bit_cnt;
        nb = fresh ? 3'h0 : q.nbytes;
        byte_in = {q.shift, si};
        if (hold_n) begin
            if (fresh) begin
                next_q.frame_tog = ~q.frame_tog;
            end
            next_q.shift = byte_in[6:0];
            next_q.bit_cnt = cnt + 3'h1;
            next_q.aligned = (cnt == sfcfe_pkg::LAST_BIT);
            next_q.nbytes = nb;
            if (cnt == sfcfe_pkg::LAST_BIT) begin
                case (nb)
                    3'h0: next_q.opcode = byte_in;
                    3'h1: next_q.arg1 = byte_in;
                    3'h2: next_q.arg2 = byte_in;
                    3'h3: next_q.arg3 = byte_in;
                    default: ;
                endcase
                if (nb != sfcfe_pkg::LEN_MAX) begin
                    next_q.nbytes = nb + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // status comes out msb first after the opcode, repeating while clocked
    assign reading = !fresh && (q.nbytes != 3'h0) && (q.opcode == sfcfe_pkg::OPC_STATUS_READ);

    always_ff @(negedge sck or posedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end else if (cs_n) begin
            so_oe_n <= 1'b1;
        end else begin
            so <= q.stat_sync[~q.bit_cnt];
            so_oe_n <= !(hold_n && reading);
        end
    end

    assign opcode = q.opcode;
    assign arg1 = q.arg1;
    assign arg2 = q.arg2;
    assign arg3 = q.arg3;
    assign nbytes = q.nbytes;
    assign aligned = q.aligned;
    assign frame_tog = q.frame_tog;

endmodule : sfcfe_link

// file: core/sfcfe_core.sv
/*
 * sfcfe_core: top of the serial flash control front end. Executes framed
 * instructions when chip select rises, keeps the status register, the busy
 * timer, write protection and the pause state.
 * Assumes a host driving sck (link clock), cs_n, si, hold_n and wp_n as pins,
 * unrelated in phase to clk; sck stands still while cs_n is high.
 */
`timescale 1ns/100ps

module sfcfe_core #(
    parameter int PROG_CYCLES = 64,
    parameter int SECTOR_CYCLES = 256,
    parameter int BLOCK_CYCLES = 512,
    parameter int CHIP_CYCLES = 1024,
    parameter bit PROTECT_TOP = 1'b1
) (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // serial link from the host
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    // serial out, three-state
    output logic so,
    output logic so_oe_n,
    // state view
    output logic [7:0] flash_status,
    output logic held
);
    typedef struct packed {
        logic [2:0] cs_sy;
        logic [1:0] sck_sy;
        logic [1:0] hold_sy;
        logic [1:0] wp_sy;
        logic frame_seen;
        logic held;
        logic write_enable_latch;
        logic [2:0] bp;
        logic lock;
        logic auto_increment_program;
        sfcfe_pkg::sfcfe_state_t state;
        logic [15:0] busy_cnt;
        logic [19:0] aai_addr;
        logic [7:0] status;
    } sfcfe_core_t;

    sfcfe_core_t q;
    sfcfe_core_t next_q;

    // refuse timer values below 2 or beyond what the 16-bit busy counter can hold
    if (PROG_CYCLES < 2 || PROG_CYCLES > 65535 || SECTOR_CYCLES < 2 || SECTOR_CYCLES > 65535
        || BLOCK_CYCLES < 2 || BLOCK_CYCLES > 65535 || CHIP_CYCLES < 2
        || CHIP_CYCLES > 65535) begin : g_bad_cycles
        $error("sfcfe_core: busy cycle counts must lie in 2..65535");
    end

    logic [7:0] opcode;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [7:0] arg3;
    logic [2:0] nbytes;
    logic aligned;
    logic frame_tog;
    logic exec;
    logic busy_now;
    logic [19:0] addr;
    logic [19:0] addr_next;

    // serial-clock side; its frame outputs are read only after cs_n has risen
    sfcfe_link u_link (
        .sck(sck),
        .reset_n(reset_n),
        .cs_n(cs_n),
        .si(si),
        .hold_n(hold_n),
        .status_word(q.status),
        .opcode(opcode),
        .arg1(arg1),
        .arg2(arg2),
        .arg3(arg3),
        .nbytes(nbytes),
        .aligned(aligned),
        .frame_tog(frame_tog),
        .so(so),
        .so_oe_n(so_oe_n)
    );

    // protected block range for a level; the variant picks top or bottom
    function automatic logic sfcfe_blocked(input logic [19:0] a, input logic [2:0] lvl);
        logic [4:0] span;
        logic [4:0] blk;
        span = 5'h0;
        blk = {1'b0, a[sfcfe_pkg::ADDR_W-1:sfcfe_pkg::BLK_LSB]};
        if (lvl >= sfcfe_pkg::LEVEL_ALL) begin
            span = sfcfe_pkg::BLOCK_COUNT;
        end else if (lvl != 3'h0) begin
            span = 5'h1 << (lvl - 3'h1);
        end
        if (PROTECT_TOP) begin
            sfcfe_blocked = blk >= (sfcfe_pkg::BLOCK_COUNT - span);
        end else begin
            sfcfe_blocked = blk < span;
        end
    endfunction : sfcfe_blocked

    // the frame bytes are stable here: the host stops sck before raising cs_n
    assign exec = q.cs_sy[1] && !q.cs_sy[2] && (frame_tog != q.frame_seen);
    assign addr = 20'({arg1, arg2, arg3}); // top address byte only partly used
    assign addr_next = q.aai_addr + sfcfe_pkg::WORD_STEP;
    assign busy_now = (q.state == sfcfe_pkg::ST_WORK);

    // next-state logic of the whole core
    always_comb begin
        next_q = q;
        // pins cross with two flops; stage one feeds stage two only
        next_q.cs_sy = {q.cs_sy[1:0], cs_n};
        next_q.sck_sy = {q.sck_sy[0], sck};
        next_q.hold_sy = {q.hold_sy[0], hold_n};
        next_q.wp_sy = {q.wp_sy[0], wp_n};

        // while selected, pause changes only in sck low phase, so an edge in the high phase waits
        if (!q.sck_sy[1] && (!q.cs_sy[1] || q.held)) begin
            next_q.held = !q.hold_sy[1];
        end else if (q.cs_sy[1] && q.hold_sy[1]) begin
            next_q.held = 1'b0;
        end

        if (exec) begin
            next_q.frame_seen = frame_tog;
        end

        case (q.state)
            sfcfe_pkg::ST_IDLE: begin
                // an aborted frame or a frame with a stray bit does nothing
                if (exec && aligned) begin
                    case (opcode)
                        sfcfe_pkg::OPC_WRITE_ENABLE_CMD: begin
                            if (nbytes == sfcfe_pkg::LEN_SHORT) begin
                                next_q.write_enable_latch = 1'b1;
                            end
                        end
                        sfcfe_pkg::OPC_WRITE_DISABLE_CMD: begin
                            if (nbytes == sfcfe_pkg::LEN_SHORT) begin
                                next_q.write_enable_latch = 1'b0;
                                next_q.auto_increment_program = 1'b0;
                            end
                        end
                        sfcfe_pkg::OPC_STATUS_WRITE_CMD: begin
                            if (nbytes == sfcfe_pkg::LEN_STATUS_WRITE) begin
                                // lock only bites while the pin is low
                                if (q.wp_sy[1] || !q.lock) begin
                                    next_q.bp = arg1[sfcfe_pkg::ST_BP_HI:sfcfe_pkg::ST_BP_LO];
                                    next_q.lock = arg1[sfcfe_pkg::ST_LOCK];
                                end
                                next_q.write_enable_latch = 1'b0;
                            end
                        end
                        sfcfe_pkg::OPC_BYTE_PROGRAM: begin
                            if (nbytes == sfcfe_pkg::LEN_PROGRAM && q.write_enable_latch
                                && !sfcfe_blocked(addr, q.bp)) begin
                                next_q.state = sfcfe_pkg::ST_WORK;
                                next_q.busy_cnt = 16'(PROG_CYCLES);
                            end
                        end
                        sfcfe_pkg::OPC_SECTOR_ERASE: begin
                            if (nbytes == sfcfe_pkg::LEN_ERASE && q.write_enable_latch
                                && !sfcfe_blocked(addr, q.bp)) begin
                                next_q.state = sfcfe_pkg::ST_WORK;
                                next_q.busy_cnt = 16'(SECTOR_CYCLES);
                            end
                        end
                        sfcfe_pkg::OPC_BLOCK_ERASE: begin
                            if (nbytes == sfcfe_pkg::LEN_ERASE && q.write_enable_latch
                                && !sfcfe_blocked(addr, q.bp)) begin
                                next_q.state = sfcfe_pkg::ST_WORK;
                                next_q.busy_cnt = 16'(BLOCK_CYCLES);
                            end
                        end
                        sfcfe_pkg::OPC_CHIP_ERASE_A, sfcfe_pkg::OPC_CHIP_ERASE_B: begin
                            if (nbytes == sfcfe_pkg::LEN_SHORT && q.write_enable_latch
                                && q.bp == 3'h0) begin
                                next_q.state = sfcfe_pkg::ST_WORK;
                                next_q.busy_cnt = 16'(CHIP_CYCLES);
                            end
                        end
                        sfcfe_pkg::OPC_AUTO_INCR: begin
                            // first word carries the address, later ones only data
                            if (!q.auto_increment_program && nbytes == sfcfe_pkg::LEN_AUTO_FIRST && q.write_enable_latch
                                && !sfcfe_blocked(addr, q.bp)) begin
                                next_q.auto_increment_program = 1'b1;
                                next_q.aai_addr = addr;
                                next_q.state = sfcfe_pkg::ST_WORK;
                                next_q.busy_cnt = 16'(PROG_CYCLES);
                            end else if (q.auto_increment_program && nbytes == sfcfe_pkg::LEN_AUTO_NEXT
                                && !sfcfe_blocked(addr_next, q.bp)) begin
                                next_q.aai_addr = addr_next;
                                next_q.state = sfcfe_pkg::ST_WORK;
                                next_q.busy_cnt = 16'(PROG_CYCLES);
                            end
                        end
                        default: ;
                    endcase
                end
            end
            sfcfe_pkg::ST_WORK: begin
                // every instruction is ignored here; status reads run on the link
                next_q.busy_cnt = q.busy_cnt - 16'h1;
                if (q.busy_cnt == 16'h1) begin
                    next_q.state = sfcfe_pkg::ST_IDLE;
                    if (!q.auto_increment_program) begin
                        next_q.write_enable_latch = 1'b0;
                    end else if (q.aai_addr >= sfcfe_pkg::TOP_ADDR - 20'h1) begin
                        // auto-increment ran to the top address
                        next_q.auto_increment_program = 1'b0;
                        next_q.write_enable_latch = 1'b0;
                    end
                end
            end
            default: next_q.state = sfcfe_pkg::ST_IDLE;
        endcase

        // status image; bit five is hard zero
        next_q.status = '0;
        next_q.status[sfcfe_pkg::ST_BUSY] = (next_q.state == sfcfe_pkg::ST_WORK);
        next_q.status[sfcfe_pkg::ST_WEL] = next_q.write_enable_latch;
        next_q.status[sfcfe_pkg::ST_BP_HI:sfcfe_pkg::ST_BP_LO] = next_q.bp;
        next_q.status[sfcfe_pkg::ST_AUTO] = next_q.auto_increment_program;
        next_q.status[sfcfe_pkg::ST_LOCK] = next_q.lock;
    end

    // power-up defaults: every block protected, latches clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.cs_sy <= 3'h7;
            q.bp <= sfcfe_pkg::PROTECT_LEVEL_RESET;
            q.status <= sfcfe_pkg::STATUS_RESET;
            q.state <= sfcfe_pkg::ST_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign flash_status = q.status;
    assign held = q.held;

    // checks on the core's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    reserved_zero_a: assert property (flash_status[sfcfe_pkg::ST_RSVD] == 1'b0)
        else $error("reserved status bit not zero");

    busy_bit_a: assert property (busy_now && q.busy_cnt != 16'h1 |=>
        flash_status[sfcfe_pkg::ST_BUSY] && q.busy_cnt == $past(q.busy_cnt) - 16'h1)
        else $error("busy bit does not track the internal operation");

    busy_min_a: assert property ($rose(busy_now) |-> busy_now [*2])
        else $error("internal operation shorter than two cycles");

    status_write_cmd_locked_a: assert property (exec && aligned && !busy_now && !q.wp_sy[1] && q.lock
        && opcode == sfcfe_pkg::OPC_STATUS_WRITE_CMD |=> $stable(q.bp) && q.lock)
        else $error("locked status write changed protection");

    wel_guard_a: assert property ($rose(busy_now) |-> $past(q.write_enable_latch))
        else $error("operation started without enable latch");

    wel_clear_a: assert property ($fell(busy_now) && !$past(q.auto_increment_program) |-> !q.write_enable_latch)
        else $error("enable latch not cleared at completion");

    chip_guard_a: assert property ($rose(busy_now) && $past(exec)
        && ($past(opcode) == sfcfe_pkg::OPC_CHIP_ERASE_A
        || $past(opcode) == sfcfe_pkg::OPC_CHIP_ERASE_B) |-> $past(q.bp) == 3'h0)
        else $error("chip erase with protection level set");

    busy_refuse_a: assert property (busy_now && exec && q.busy_cnt != 16'h1
        |=> $stable(q.bp) && $stable(q.lock) && $stable(q.write_enable_latch))
        else $error("instruction served while busy");

    abort_frame_a: assert property (exec && !aligned && !busy_now
        |=> $stable(q.write_enable_latch) && $stable(q.bp) && !busy_now)
        else $error("aborted frame had an effect");

    pause_low_a: assert property (!q.sck_sy[1] && !q.cs_sy[1]
        |=> q.held == !$past(q.hold_sy[1]))
        else $error("pause state missed a low-phase edge");

    pause_high_a: assert property (q.sck_sy[1] && !q.cs_sy[1] |=> $stable(q.held))
        else $error("pause changed during sck high phase");

endmodule : sfcfe_core

// file: verification/sfcfe_host_model.sv
/*
 * sfcfe_host_model: host SPI controller that frames instructions for the
 * front end, mode 0, 32 ns sck that runs only inside frames.
 * Assumes the bench calls frame from one process at a time.
 */
`timescale 1ns/100ps
module sfcfe_host_model (
    // serial pins to the device
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    // serial pins and probe from the device
    input wire logic so,
    input wire logic so_oe_n,
    input wire logic held,
    // pause result
    output logic held_ok
);
    // idle: deselected, clock parked low
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
        held_ok = 1'b0;
    end

    // send n bits msb first; a pause is taken after bit hb when hb is not negative
    task automatic frame(input logic [39:0] d, input int n, input int hb,
                         output logic [7:0] rd);
        int i;
        rd = 8'h00;
        #3 cs_n = 1'b0;
        #16;
        for (i = 0; i < n; i++) begin
            si = d[39 - i];
            #16 sck = 1'b1;
            rd = {rd[6:0], so_oe_n ? ~so : so}; // a floating line reads as the inverse
            if (i == hb) begin
                // fall with sck high so entry waits for sck low
                #8 hold_n = 1'b0;
                #8 sck = 1'b0;
                // noise on clock and data that the paused device must ignore
                repeat (3) begin
                    #16 si = ~si;
                    sck = 1'b1;
                    #16 sck = 1'b0;
                end
                #200 held_ok = (held === 1'b1) && (so_oe_n === 1'b1);
                hold_n = 1'b1;
                #16;
            end else begin
                #16 sck = 1'b0;
            end
        end
        #16 cs_n = 1'b1;
        si = ~si; // released line shows no stale level
        // select stays high over five clk periods so the core can execute
        #200;
    endtask : frame
endmodule : sfcfe_host_model

// file: verification/tb_top.sv
/*
 * tb_top: self-checking bench of the serial flash control front end.
 * Assumes the host model makes the serial traffic; the bench drives reset
 * and wp_n at falling clk and notes the expected status image per frame.
 */
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n = 1'b1;
    logic sck, cs_n, si, hold_n, so, so_oe_n, held, held_ok;
    logic [7:0] flash_status;
    logic [7:0] rd;
    logic [7:0] v;
    logic [7:0] exp_q[$];
    int seed = 32'h05d54e3c;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    event chk;

    // 25 MHz system clock
    always #20 clk = ~clk;

    // short erase counts keep the run brief; program long enough to poll
    sfcfe_core #(.PROG_CYCLES(64), .SECTOR_CYCLES(6), .BLOCK_CYCLES(8),
                 .CHIP_CYCLES(10), .PROTECT_TOP(1'b1)) sfcfe_core_i (
        .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
        .flash_status(flash_status), .held(held));

    sfcfe_host_model sfcfe_host_model_i (
        .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
        .so_oe_n(so_oe_n), .held(held), .held_ok(held_ok));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // note an expected status image and wake the watcher
    task automatic note(input logic [7:0] e);
        exp_q.push_back(e);
        ->chk;
    endtask : note

    // one frame, then time for the clk side to execute it
    task automatic cmd(input logic [39:0] d, input int n, input int hb, input logic [7:0] e);
        sfcfe_host_model_i.frame(d, n, hb, rd);
        repeat (8) @(negedge clk);
        note(e);
    endtask : cmd

    // watcher: oldest note against the status image
    always @(chk) begin
        check("flash_status", flash_status, exp_q.pop_front());
    end

    // hang guard, well above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        note(8'h1C);
        sfcfe_host_model_i.frame({8'h05, 32'h0}, 16, -1, rd);
        check("status read", rd, 8'h1C);
        // random writes: only level and lock bits land
        repeat (4) begin
            v = 8'($random(seed));
            cmd({8'h01, v, 24'h0}, 16, -1, v & 8'h9C);
        end
        cmd({8'h01, 8'h80, 24'h0}, 16, -1, 8'h80);
        wp_n = 1'b0;
        cmd({8'h01, 8'h1C, 24'h0}, 16, -1, 8'h80);
        wp_n = 1'b1;
        cmd({8'h01, 8'h00, 24'h0}, 16, -1, 8'h00);
        cmd({8'h06, 32'h0}, 8, -1, 8'h02);
        cmd({8'h04, 32'h0}, 8, -1, 8'h00);
        cmd({8'h06, 32'h0}, 8, -1, 8'h02);
        cmd({8'h01, 8'h00, 24'h0}, 16, -1, 8'h00);
        cmd({8'h02, 24'h000010, 8'h55}, 40, -1, 8'h00);
        cmd({8'h06, 32'h0}, 5, -1, 8'h00);
        // program, then poll and try a refused command while busy
        cmd({8'h06, 32'h0}, 8, -1, 8'h02);
        cmd({8'h02, 24'h000010, 8'h55}, 40, -1, 8'h03);
        sfcfe_host_model_i.frame({8'h05, 32'h0}, 16, -1, rd);
        check("busy poll", rd, 8'h03);
        cmd({8'h04, 32'h0}, 8, -1, 8'h03);
        repeat (64) @(negedge clk);
        note(8'h00);
        // chip erase with a nonzero level is refused
        cmd({8'h01, 8'h04, 24'h0}, 16, -1, 8'h04);
        cmd({8'h06, 32'h0}, 8, -1, 8'h06);
        cmd({8'h60, 32'h0}, 8, -1, 8'h06);
        // pause in mid-frame; the write must still complete intact
        cmd({8'h01, 8'h9C, 24'h0}, 16, 10, 8'h9C);
        check("pause", {7'h00, held_ok}, 8'h01);
        // pause during a status read must float so
        sfcfe_host_model_i.frame({8'h05, 32'h0}, 16, 12, rd);
        check("pause read", {7'h00, held_ok}, 8'h01);
        // clear the level, then a sector erase runs to completion
        cmd({8'h01, 8'h00, 24'h0}, 16, -1, 8'h00);
        cmd({8'h06, 32'h0}, 8, -1, 8'h02);
        cmd({8'h20, 24'h001000, 8'h00}, 32, -1, 8'h00);
        wrap_up();
    end
endmodule : tb_top
